// >>> rgc_pkg.sv
package rgc_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_SETPOINT   = 8'h00;
    localparam logic [7:0] ADDR_PRIMARY    = 8'h01;
    localparam logic [7:0] ADDR_RANGE_SS   = 8'h02;
    localparam logic [7:0] ADDR_STACKING   = 8'h03;
    localparam logic [7:0] ADDR_FAULT      = 8'h04;

    // Primary control field positions
    localparam int BIT_RESET       = 7;
    localparam int BIT_SPREAD      = 6;
    localparam int BIT_SWITCH      = 5;
    localparam int BIT_FPWM        = 4;
    localparam int BIT_DISCHARGE   = 3;
    localparam int BIT_RETRY       = 2;
    localparam int SLEW_HI         = 1;
    localparam int SLEW_LO         = 0;

    // Range/soft-start field positions
    localparam int RANGE_HI        = 3;
    localparam int RANGE_LO        = 2;
    localparam int SOFT_START_TIME_SELECT_HI       = 1;
    localparam int SOFT_START_TIME_SELECT_LO       = 0;

    // Reset values
    localparam logic [7:0] PRIMARY_RST   = 8'h2A;
    localparam logic [1:0] SOFT_START_TIME_SELECT_RST    = 2'h1;
    localparam logic [1:0] STACKING_RST  = 2'h0;
    localparam logic [7:0] READ_ZERO     = 8'h00;

    // Setpoint arithmetic, in units of 1.25 mV
    localparam int         LEVEL_W       = 12;
    localparam logic [11:0] BASE_LOW     = 12'h140;  // 0.4 V
    localparam logic [11:0] BASE_HIGH    = 12'h280;  // 0.8 V
    localparam logic [1:0] RANGE_FOURTH  = 2'h3;

    // Slew codes and rates
    localparam logic [1:0] SLEW_10MV     = 2'h0;
    localparam logic [1:0] SLEW_5MV      = 2'h1;
    localparam logic [1:0] SLEW_1M25     = 2'h2;
    localparam logic [1:0] SLEW_0M5      = 2'h3;
    localparam int RATE_10MV_UV_US       = 10000;
    localparam int RATE_5MV_UV_US        = 5000;
    localparam int RATE_1M25_UV_US       = 1250;
    localparam int RATE_0M5_UV_US        = 500;
    localparam int LSB_UV                = 1250;
    localparam int CLK_PERIOD_PS         = 4000;

    // Cycles per 1.25 mV step: least time rounds down to keep rate honest
    localparam int CYC_10MV  = LSB_UV * 1000000 / (RATE_10MV_UV_US * CLK_PERIOD_PS);
    localparam int CYC_5MV   = LSB_UV * 1000000 / (RATE_5MV_UV_US * CLK_PERIOD_PS);
    localparam int CYC_1M25  = LSB_UV * 1000000 / (RATE_1M25_UV_US * CLK_PERIOD_PS);
    localparam int CYC_0M5   = LSB_UV * 1000000 / (RATE_0M5_UV_US * CLK_PERIOD_PS);
    localparam int RAMP_CNT_W = 10;

    // Block operating states
    typedef enum logic [2:0] {
        ST_INIT    = 3'b001,
        ST_STANDBY = 3'b010,
        ST_ON      = 3'b100
    } rgc_state_t;

endpackage : rgc_pkg

// >>> rgc_sp_if.sv
`timescale 1ns/10ps
`default_nettype none

interface rgc_sp_if;
    logic [7:0]  code;
    logic [1:0]  range;
    logic [1:0]  slew;
    logic        track;
    logic [11:0] level;
    logic        settled;

    modport ctrl (output code, output range, output slew, output track,
                  input level, input settled);
    modport ramp (input code, input range, input slew, input track,
                  output level, output settled);
endinterface : rgc_sp_if

`default_nettype wire

// >>> rgc_setpoint_ramp.sv
`timescale 1ns/10ps
`default_nettype none

module rgc_setpoint_ramp (
    input  wire logic  sys_clk,
    input  wire logic  rst,
    rgc_sp_if.ramp     sp
);
    logic [11:0]                    target;
    logic [11:0]                    level_r;
    logic [11:0]                    level_nxt;
    logic [rgc_pkg::RAMP_CNT_W-1:0] cnt_r;
    logic [rgc_pkg::RAMP_CNT_W-1:0] cnt_nxt;
    logic [rgc_pkg::RAMP_CNT_W-1:0] period;

    // Base plus code scaled by range step; shift by range gives x1,x2,x4,x8
    always_comb begin
        if (sp.range == rgc_pkg::RANGE_FOURTH) begin
            target = rgc_pkg::BASE_HIGH + ({4'h0, sp.code} << sp.range); // [R3] [R17]
        end else begin
            target = rgc_pkg::BASE_LOW + ({4'h0, sp.code} << sp.range);  // [R2] [R17]
        end
    end

    // Step interval per slew code
    always_comb begin
        case (sp.slew)
            rgc_pkg::SLEW_10MV: period = rgc_pkg::RAMP_CNT_W'(rgc_pkg::CYC_10MV - 1); // [R13]
            rgc_pkg::SLEW_5MV:  period = rgc_pkg::RAMP_CNT_W'(rgc_pkg::CYC_5MV - 1);
            rgc_pkg::SLEW_1M25: period = rgc_pkg::RAMP_CNT_W'(rgc_pkg::CYC_1M25 - 1);
            default:            period = rgc_pkg::RAMP_CNT_W'(rgc_pkg::CYC_0M5 - 1);
        endcase
    end

    // One LSB per interval while tracking; jump straight when not switching
    always_comb begin
        level_nxt = level_r;
        cnt_nxt   = cnt_r;
        if (!sp.track) begin
            level_nxt = target;
            cnt_nxt   = period;
        end else if (level_r == target) begin
            cnt_nxt = period;
        end else if (cnt_r == '0) begin
            level_nxt = (level_r < target) ? level_r + 12'h001 : level_r - 12'h001; // [R13]
            cnt_nxt   = period;
        end else begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            level_r <= '0;
            cnt_r   <= '0;
        end else begin
            level_r <= level_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    assign sp.level   = level_r;
    assign sp.settled = (level_r == target);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_level_follows_target: assert property (!sp.track |=> level_r == $past(target)) // [R2] [R3]
        else $error("level did not follow target while idle");
    chk_fast_slew_space: assert property (
        sp.track && $changed(level_r) && sp.slew == 2'h0 && $stable(sp.slew)
        |=> $stable(level_r) [*8]) // [R13]
        else $error("steps too close at fastest slew");
    cov_ramp_step: cover property (sp.track && $changed(level_r));
endmodule : rgc_setpoint_ramp

`default_nettype wire

// >>> rgc_regulator_ctrl.sv
// Overview of operation
// [R1] - Controller treats addresses beyond the five registers as reserved, never writes them.
// [R2] - Ranges one to three: setpoint is 0.4 V plus code times 1.25/2.5/5 mV.
// [R3] - Fourth range: setpoint is 0.8 V plus code times 10 mV.
// [R4] - Setpoint reset value comes from strap pins sampled at power-up.
// [R5] - Writing one to reset bit restores all defaults and reinitialises.
// [R6] - Reset bit always reads back as zero.
// [R7] - Spread-spectrum bit enables or disables switching clock spreading.
// [R8] - Clearing switch enable stops switching, keeps registers; setting starts without delay.
// [R9] - Forced PWM when bit set or mode/sync pin high or clocked; else power-save.
// [R10] - Discharge bit enables or disables active output discharge.
// [R11] - Overcurrent retry mode only when its bit is one.
// [R12] - Controller should not enable retry mode in stacked operation.
// [R13] - Slew field picks 10, 5, 1.25 or 0.5 mV per microsecond.
// [R14] - Primary control resets to 2Ah.
// [R15] - Reads of undefined addresses return zero.
// [R16] - Written byte commits on falling edge of its data acknowledge.
// [R17] - Range field selects one of four setpoint ranges.
// [R18] - Clearing switch enable leaves On and enters standby.
`timescale 1ns/10ps
`default_nettype none

module rgc_regulator_ctrl #(
    parameter int STRAP_W = 10
) (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr_commit,
    input  wire logic               reg_rd_req,
    output logic [7:0]              reg_rdata,
    input  wire logic [STRAP_W-1:0] setpoint_strap_pins,
    input  wire logic               en_pin,
    input  wire logic               mode_sync_active,
    input  wire logic [7:0]         fault_flags_in,
    output logic                    init_busy,
    output logic                    switching_on,
    output logic                    spread_spectrum_enable,
    output logic                    forced_pwm_active,
    output logic                    output_discharge_enable,
    output logic                    overcurrent_retry_enable,
    output logic [1:0]              soft_start_time_select,
    output logic [1:0]              stacking_control_bits,
    output logic [11:0]             setpoint_level,
    output logic                    setpoint_settled
);
    rgc_pkg::rgc_state_t state_r;
    rgc_pkg::rgc_state_t state_nxt;
    logic [7:0]          setpoint_r;
    logic [7:0]          setpoint_nxt;
    logic [6:0]          primary_r;       // Reset bit is not stored
    logic [6:0]          primary_nxt;
    logic [1:0]          range_r;
    logic [1:0]          range_nxt;
    logic [1:0]          soft_start_time_select_r;
    logic [1:0]          soft_start_time_select_nxt;
    logic [1:0]          stacking_r;
    logic [1:0]          stacking_nxt;
    logic [7:0]          rdata_r;
    logic [7:0]          rdata_nxt;
    logic                accessible;

    rgc_sp_if sp ();

    assign accessible = (state_r != rgc_pkg::ST_INIT);

    // Register writes, strap capture and standby/on sequencing
    always_comb begin
        state_nxt    = state_r;
        setpoint_nxt = setpoint_r;
        primary_nxt  = primary_r;
        range_nxt    = range_r;
        soft_start_time_select_nxt   = soft_start_time_select_r;
        stacking_nxt = stacking_r;
        case (state_r)
            rgc_pkg::ST_INIT: begin
                // Straps are caught here, never under the async reset
                setpoint_nxt = setpoint_strap_pins[7:0];                      // [R4]
                range_nxt    = setpoint_strap_pins[9:8];                      // [R17]
                primary_nxt  = rgc_pkg::PRIMARY_RST[6:0];                     // [R14]
                soft_start_time_select_nxt   = rgc_pkg::SOFT_START_TIME_SELECT_RST;
                stacking_nxt = rgc_pkg::STACKING_RST;
                state_nxt    = rgc_pkg::ST_STANDBY;
            end
            rgc_pkg::ST_STANDBY, rgc_pkg::ST_ON: begin
                // Commit strobe marks the falling edge of the data acknowledge
                if (reg_wr_commit) begin                                      // [R16]
                    if (reg_addr == rgc_pkg::ADDR_SETPOINT) begin
                        setpoint_nxt = reg_wdata;
                    end else if (reg_addr == rgc_pkg::ADDR_PRIMARY) begin
                        // A reset write must not flash its other bits onto the outputs
                        if (reg_wdata[rgc_pkg::BIT_RESET]) begin              // [R5]
                            primary_nxt = rgc_pkg::PRIMARY_RST[6:0];
                        end else begin
                            primary_nxt = reg_wdata[6:0];                     // [R6]
                        end
                    end else if (reg_addr == rgc_pkg::ADDR_RANGE_SS) begin
                        range_nxt  = reg_wdata[rgc_pkg::RANGE_HI:rgc_pkg::RANGE_LO];
                        soft_start_time_select_nxt = reg_wdata[rgc_pkg::SOFT_START_TIME_SELECT_HI:rgc_pkg::SOFT_START_TIME_SELECT_LO];
                    end else if (reg_addr == rgc_pkg::ADDR_STACKING) begin
                        stacking_nxt = reg_wdata[1:0];
                    end
                end
                // Switch enable takes effect on the same edge it is written
                if (en_pin && primary_nxt[rgc_pkg::BIT_SWITCH]) begin         // [R8]
                    state_nxt = rgc_pkg::ST_ON;
                end else begin
                    state_nxt = rgc_pkg::ST_STANDBY;                          // [R18]
                end
                // Software reset overrides any other change
                if (reg_wr_commit && reg_addr == rgc_pkg::ADDR_PRIMARY
                    && reg_wdata[rgc_pkg::BIT_RESET]) begin                   // [R5]
                    state_nxt = rgc_pkg::ST_INIT;
                end
            end
            default: begin
                state_nxt = rgc_pkg::ST_INIT;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r    <= rgc_pkg::ST_INIT;
            setpoint_r <= '0;
            primary_r  <= rgc_pkg::PRIMARY_RST[6:0];                          // [R14]
            range_r    <= '0;
            soft_start_time_select_r   <= rgc_pkg::SOFT_START_TIME_SELECT_RST;
            stacking_r <= rgc_pkg::STACKING_RST;
        end else begin
            state_r    <= state_nxt;
            setpoint_r <= setpoint_nxt;
            primary_r  <= primary_nxt;
            range_r    <= range_nxt;
            soft_start_time_select_r   <= soft_start_time_select_nxt;
            stacking_r <= stacking_nxt;
        end
    end

    // Read data; held between requests, zero while initialising
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd_req) begin
            if (!accessible) begin
                rdata_nxt = rgc_pkg::READ_ZERO;
            end else if (reg_addr == rgc_pkg::ADDR_SETPOINT) begin
                rdata_nxt = setpoint_r;
            end else if (reg_addr == rgc_pkg::ADDR_PRIMARY) begin
                rdata_nxt = {1'b0, primary_r};                                // [R6]
            end else if (reg_addr == rgc_pkg::ADDR_RANGE_SS) begin
                rdata_nxt = {4'h0, range_r, soft_start_time_select_r};
            end else if (reg_addr == rgc_pkg::ADDR_STACKING) begin
                rdata_nxt = {6'h00, stacking_r};
            end else if (reg_addr == rgc_pkg::ADDR_FAULT) begin
                rdata_nxt = fault_flags_in;
            end else begin
                rdata_nxt = rgc_pkg::READ_ZERO;                               // [R15]
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Ramp engine; tracks only while switching, jumps otherwise
    assign sp.code  = setpoint_r;
    assign sp.range = range_r;
    assign sp.slew  = primary_r[rgc_pkg::SLEW_HI:rgc_pkg::SLEW_LO];          // [R13]
    assign sp.track = (state_r == rgc_pkg::ST_ON);

    rgc_setpoint_ramp u_ramp (
        .sys_clk (sys_clk),
        .rst     (rst),
        .sp      (sp)
    );

    // Control outputs from register bits, state and the ramp; forced PWM also takes the pin
    assign reg_rdata                = rdata_r;
    assign init_busy                = (state_r == rgc_pkg::ST_INIT);
    assign switching_on             = (state_r == rgc_pkg::ST_ON);            // [R8] [R18]
    assign spread_spectrum_enable   = primary_r[rgc_pkg::BIT_SPREAD];         // [R7]
    // Pin wins over a cleared bit: either source forces PWM
    assign forced_pwm_active        = primary_r[rgc_pkg::BIT_FPWM] | mode_sync_active; // [R9]
    assign output_discharge_enable  = primary_r[rgc_pkg::BIT_DISCHARGE];      // [R10]
    assign overcurrent_retry_enable = primary_r[rgc_pkg::BIT_RETRY];          // [R11]
    assign soft_start_time_select   = soft_start_time_select_r;
    assign stacking_control_bits    = stacking_r;
    assign setpoint_level           = sp.level;
    assign setpoint_settled         = sp.settled;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_reset_bit_zero: assert property ( // [R6]
        reg_rd_req && reg_addr == rgc_pkg::ADDR_PRIMARY |=> reg_rdata[7] == 1'b0)
        else $error("reset bit read back as one");
    chk_unmapped_read: assert property ( // [R15]
        reg_rd_req && reg_addr > rgc_pkg::ADDR_FAULT |=> reg_rdata == 8'h00)
        else $error("unmapped address read nonzero");
    chk_setpoint_commit: assert property ( // [R16]
        reg_wr_commit && accessible && reg_addr == rgc_pkg::ADDR_SETPOINT
        |=> setpoint_r == $past(reg_wdata))
        else $error("setpoint write not committed");
    chk_soft_reset_seq: assert property ( // [R5] [R14]
        reg_wr_commit && accessible && reg_addr == rgc_pkg::ADDR_PRIMARY && reg_wdata[7]
        |=> (init_busy && primary_r == 7'h2A) ##1 (!init_busy && primary_r == 7'h2A))
        else $error("software reset did not restore defaults");
    chk_strap_load: assert property ( // [R4]
        init_busy |=> setpoint_r == $past(setpoint_strap_pins[7:0]))
        else $error("setpoint not loaded from straps");
    chk_switch_off: assert property ( // [R8] [R18]
        !init_busy && !primary_r[rgc_pkg::BIT_SWITCH] |-> !switching_on)
        else $error("switching while enable cleared");
    // A write in the same cycle decides, since enable acts on the edge it lands
    chk_switch_on_now: assert property ( // [R8]
        accessible && en_pin
        && ((reg_wr_commit && reg_addr == rgc_pkg::ADDR_PRIMARY)
            ? (reg_wdata[rgc_pkg::BIT_SWITCH] && !reg_wdata[rgc_pkg::BIT_RESET])
            : primary_r[rgc_pkg::BIT_SWITCH])
        |=> switching_on)
        else $error("switching start delayed");
    chk_fpwm_or: assert property ( // [R9]
        reg_wr_commit && accessible && reg_addr == rgc_pkg::ADDR_PRIMARY
        && !reg_wdata[rgc_pkg::BIT_RESET]
        |=> forced_pwm_active == ($past(reg_wdata[rgc_pkg::BIT_FPWM]) | mode_sync_active))
        else $error("forced pwm select wrong");
    chk_ctrl_bits: assert property ( // [R7] [R10] [R11]
        reg_wr_commit && accessible && reg_addr == rgc_pkg::ADDR_PRIMARY && !reg_wdata[7]
        |=> spread_spectrum_enable == $past(reg_wdata[6])
            && output_discharge_enable == $past(reg_wdata[3])
            && overcurrent_retry_enable == $past(reg_wdata[2]))
        else $error("control bits not applied");

    cov_soft_reset: cover property (reg_wr_commit && reg_addr == 8'h01 && reg_wdata[7]);
    cov_enter_on: cover property (!switching_on ##1 switching_on);
    cov_read_status: cover property (reg_rd_req && reg_addr == 8'h04);
endmodule : rgc_regulator_ctrl

`default_nettype wire

// >>> rgc_bus_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none

// Bus-controller stand-in: one byte per call, launched off the falling edge
module rgc_bus_ctrl_model #(
    parameter bit STACKED = 1'b0
) (
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr_commit,
    output var  logic       reg_rd_req
);
    // Idle bus at time zero
    initial begin
        reg_addr      = 8'h00;
        reg_wdata     = 8'h00;
        reg_wr_commit = 1'b0;
        reg_rd_req    = 1'b0;
    end

    // Commit pulse stands one cycle; reserved places are never written
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a > rgc_pkg::ADDR_FAULT) return;
        @(negedge sys_clk);
        reg_addr      <= a;
        reg_wdata     <= (STACKED && a == rgc_pkg::ADDR_PRIMARY) ? (d & 8'hFB) : d;
        reg_wr_commit <= 1'b1;
        @(negedge sys_clk);
        reg_wr_commit <= 1'b0;
        reg_wdata     <= ~reg_wdata; // Stale data never looks valid
        @(negedge sys_clk);
    endtask : wr

    // Data sampled two cycles after the request is launched, so latency slack is harmless
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_addr   <= a;
        reg_rd_req <= 1'b1;
        @(negedge sys_clk);
        reg_rd_req <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask : rd
endmodule : rgc_bus_ctrl_model

`default_nettype wire

// >>> rgc_regulator_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none

module rgc_regulator_ctrl_bench;
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, fault_flags_in, rd;
    logic        reg_wr_commit, reg_rd_req, en_pin, mode_sync_active, init_busy;
    logic        switching_on, spread_spectrum_enable, forced_pwm_active, setpoint_settled;
    logic        output_discharge_enable, overcurrent_retry_enable;
    logic [9:0]  setpoint_strap_pins;
    logic [1:0]  soft_start_time_select, stacking_control_bits;
    logic [11:0] setpoint_level;
    int          err_total  = 0;
    int          num_checks = 0;
    int          cyc        = 0;
    int          mreg [0:3];
    int          rate [0:3] = '{10000, 5000, 1250, 500};
    logic [7:0]  wmask [0:3] = '{8'hFF, 8'h7F, 8'h0F, 8'h03};
    logic [7:0]  amap [0:7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h7F, 8'hFF};

    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;

    // Hang guard, well above the slowest ramp
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            $display("BAD timeout expected finish seen hang");
            tally_and_finish();
        end
    end

    rgc_regulator_ctrl dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr_commit(reg_wr_commit), .reg_rd_req(reg_rd_req),
        .reg_rdata(reg_rdata), .setpoint_strap_pins(setpoint_strap_pins), .en_pin(en_pin),
        .mode_sync_active(mode_sync_active), .fault_flags_in(fault_flags_in),
        .init_busy(init_busy), .switching_on(switching_on),
        .spread_spectrum_enable(spread_spectrum_enable), .forced_pwm_active(forced_pwm_active),
        .output_discharge_enable(output_discharge_enable),
        .overcurrent_retry_enable(overcurrent_retry_enable),
        .soft_start_time_select(soft_start_time_select),
        .stacking_control_bits(stacking_control_bits), .setpoint_level(setpoint_level),
        .setpoint_settled(setpoint_settled));

    rgc_bus_ctrl_model ctrl (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr_commit(reg_wr_commit), .reg_rd_req(reg_rd_req));

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        num_checks++;
        if (exp !== got) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Defaults, with strap levels taken fresh each time
    task automatic model_reset();
        mreg[0] = int'(setpoint_strap_pins[7:0]);
        mreg[1] = 8'h2A;
        mreg[2] = int'({setpoint_strap_pins[9:8], 2'b01});
        mreg[3] = 0;
    endtask : model_reset

    function automatic logic [7:0] mexp(input logic [7:0] a);
        if (a < 8'h04) return 8'(mreg[a]);
        if (a == 8'h04) return fault_flags_in;
        return 8'h00;
    endfunction : mexp

    // Level in 1.25 mV units: the wide range has its own base and 8x step
    function automatic logic [11:0] target();
        logic [1:0] r;
        r = 2'(mreg[2] >> 2);
        if (r == 2'h3) return 12'(640 + mreg[0] * 8);
        return 12'(320 + (mreg[0] << r));
    endfunction : target

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ctrl.wr(a, d);
        if (a == 8'h01 && d[7]) model_reset();
        else if (a < 8'h04) mreg[a] = int'(d & wmask[a]);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a);
        ctrl.rd(a, rd);
        chk($sformatf("reg %h", a), mexp(a), 12'(rd));
    endtask : rd_chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        void'($urandom(9642));
        en_pin = 1'b0;
        mode_sync_active = 1'b0;
        fault_flags_in = 8'($urandom);
        setpoint_strap_pins = 10'($urandom);
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        model_reset();
        repeat (2) @(negedge sys_clk);
        chk("init_busy", 12'h000, 12'(init_busy));
        foreach (amap[i]) rd_chk(amap[i]);
        $display("test reset_values done");
        // Every range at the top code, switching off so level follows at once
        for (int r = 0; r < 4; r++) begin
            wr(8'h02, 8'(r << 2));
            wr(8'h00, 8'hFF);
            chk("level", target(), setpoint_level);
        end
        $display("test ranges done");
        // Random traffic over all five places, reset bit kept clear
        for (int i = 0; i < 30; i++) begin
            logic [7:0] a;
            a = 8'(i % 5);
            mode_sync_active = 1'($urandom);
            wr(a, 8'($urandom) & 8'h7F);
            rd_chk(a);
            chk("spread", 12'(mreg[1][6]), 12'(spread_spectrum_enable));
            chk("fpwm", 12'(mreg[1][4] | mode_sync_active), 12'(forced_pwm_active));
            chk("discharge", 12'(mreg[1][3]), 12'(output_discharge_enable));
            chk("retry", 12'(mreg[1][2]), 12'(overcurrent_retry_enable));
            chk("soft_start_time_select", 12'(mreg[2][1:0]), 12'(soft_start_time_select));
            chk("stack", 12'(mreg[3][1:0]), 12'(stacking_control_bits));
            chk("level", target(), setpoint_level);
        end
        $display("test random_access done");
        en_pin = 1'b1;
        wr(8'h01, 8'h20);
        chk("on", 12'h001, 12'(switching_on));
        wr(8'h01, 8'h00);
        chk("on", 12'h000, 12'(switching_on));
        rd_chk(8'h00);
        rd_chk(8'h02);
        $display("test switching done");
        // Two-step ramp at each slew code; first step may wait up to one interval
        for (int s = 0; s < 4; s++) begin
            int iv;
            int n;
            iv = 1250 * 250 / rate[s];
            wr(8'h02, 8'h01);
            wr(8'h01, 8'(s));
            wr(8'h00, 8'h10);
            wr(8'h01, 8'(8'h20 | s));
            wr(8'h00, 8'h12);
            n = 2;
            while (setpoint_settled !== 1'b1 && n < 2000) begin
                @(negedge sys_clk);
                n++;
            end
            chk("ramp window", 12'h001, 12'(n >= iv && n <= 2 * iv + 4));
            chk("level", target(), setpoint_level);
        end
        $display("test ramp done");
        setpoint_strap_pins = 10'($urandom);
        wr(8'h01, 8'h80);
        repeat (2) @(negedge sys_clk);
        foreach (amap[i]) rd_chk(amap[i]);
        chk("discharge", 12'h001, 12'(output_discharge_enable));
        $display("test soft_reset done");
        // Power-up again mid-run: straps taken fresh, registers back to defaults
        setpoint_strap_pins = 10'($urandom);
        rst = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk("init_busy", 12'h001, 12'(init_busy));
        rst = 1'b0;
        model_reset();
        repeat (2) @(negedge sys_clk);
        foreach (amap[i]) rd_chk(amap[i]);
        chk("level", target(), setpoint_level);
        $display("test hard_reset done");
        tally_and_finish();
    end
endmodule : rgc_regulator_ctrl_bench

`default_nettype wire
